// ### rtl/ufp_pkg.sv
// ufp_pkg: constants and carrier types for the two-channel FIFO data port.
// assumes an 11-bit byte address into the channel memory region and 32-bit host data.
package ufp_pkg;

	localparam int NUM_CH = 2;
	localparam int ADDR_W = 11;
	localparam int DATA_W = 32;
	localparam int LANES = 4;
	localparam int FIFO_DEPTH = 256;
	localparam int TX_W = 8;
	localparam int RX_W = 16;

	// register offsets as the host sees them
	localparam logic [ADDR_W-1:0] OFS_CH0_HOLDING = 11'h000;
	localparam logic [ADDR_W-1:0] OFS_CH0_BURST = 11'h100;
	localparam logic [ADDR_W-1:0] OFS_CH0_RX_STATUS = 11'h200;
	localparam logic [ADDR_W-1:0] OFS_CH1_HOLDING = 11'h400;
	localparam logic [ADDR_W-1:0] OFS_CH1_BURST = 11'h500;
	localparam logic [ADDR_W-1:0] OFS_CH1_RX_STATUS = 11'h600;

	// address field positions: channel bit, window select, word offset in window
	localparam int POS_CH = 10;
	localparam int POS_WIN_HI = 9;
	localparam int POS_WIN_LO = 8;
	localparam int POS_WORD_HI = 7;
	localparam int POS_WORD_LO = 2;

	// window codes taken from address bits [9:8]
	localparam logic [1:0] WIN_HOLDING = 2'h0;
	localparam logic [1:0] WIN_BURST = 2'h1;

	localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;
	localparam logic [7:0] EMPTY_BYTE = 8'h00;
	localparam logic [1:0] LANE_FIRST = 2'h0;
	localparam logic [1:0] LANE_LAST = 2'h3;

	typedef struct packed {
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [LANES-1:0] be;
		logic [DATA_W-1:0] wdata;
	} ufp_req_t;

	typedef struct packed {
		logic [7:0] line_status_byte;
		logic [7:0] data;
	} ufp_rx_entry_t;

endpackage

// ### rtl/ufp_fifo.sv
// ufp_fifo: synchronous FIFO with a registered output stage.
// assumes one clock; width and depth are parameters, depth a power of two.
`timescale 1ns/1ps
module ufp_fifo
	import ufp_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;
	logic [AW:0] count_d;
	logic full_q;
	// ready kept in its own flop so the port is driven straight from a register
	logic in_ready_q;
	logic out_valid_q;
	logic [WIDTH-1:0] out_data_q;
	logic push;
	logic load;

	assign push = in_valid && !full_q;
	// the output register refills as soon as its word is taken, so it never bubbles
	assign load = (count_q != '0) && (!out_valid_q || out_ready);
	assign count_d = count_q + (AW+1)'(push) - (AW+1)'(load);

	assign in_ready = in_ready_q;
	assign out_valid = out_valid_q;
	assign out_data = out_data_q;

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wr_ptr_q] <= in_data;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
			full_q <= 1'b0;
			in_ready_q <= 1'b1;
		end else begin
			wr_ptr_q <= wr_ptr_q + AW'(push);
			rd_ptr_q <= rd_ptr_q + AW'(load);
			count_q <= count_d;
			full_q <= (count_d == DEPTH_CNT);
			in_ready_q <= (count_d != DEPTH_CNT);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_valid_q <= 1'b0;
			out_data_q <= '0;
		end else if (load) begin
			out_valid_q <= 1'b1;
			out_data_q <= mem[rd_ptr_q];
		end else if (out_ready) begin
			out_valid_q <= 1'b0;
		end
	end

	property p_fifo_bound;
		@(posedge ref_clk) disable iff (!rst_n)
		count_q <= DEPTH_CNT && (full_q == (count_q == DEPTH_CNT)) && (in_ready_q == !full_q);
	endproperty
	a_fifo_bound: assert property (p_fifo_bound)
		else $error("fifo count out of range or full flag wrong");

endmodule

// ### rtl/ufp_data_port.sv
// ufp_data_port: host data access to the transmit and receive FIFOs of two channels.
// assumes host requests one aligned word at a time, bursts arriving as back-to-back words.
// How it works
// - each channel has 256-byte transmit and receive FIFOs
// - burst window takes 8 to 32-bit accesses
// - status window pairs each byte with status
// - bursts move up to 256 bytes
// - bursts honoured anywhere in burst and status windows
// - holding port moves one byte per access
// - window 0xM00-0xMFF pops on read, pushes on write
// - status window spans 512 bytes per channel
// - word read returns oldest byte in lane 0
// - status read: status n, data n, repeated
// - word write pushes lane 0 first, then upward
// - holding byte write pushes, byte read pops
`timescale 1ns/1ps
module ufp_data_port
	import ufp_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire ufp_req_t req,
	output logic req_ready,
	output logic rsp_valid,
	output logic [DATA_W-1:0] rsp_rdata,
	output logic [NUM_CH-1:0] tx_valid,
	output logic [NUM_CH-1:0][TX_W-1:0] tx_data,
	input wire logic [NUM_CH-1:0] tx_ready,
	input wire logic [NUM_CH-1:0] rx_valid,
	input wire ufp_rx_entry_t [NUM_CH-1:0] rx_entry,
	output logic [NUM_CH-1:0] rx_ready
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_LANE,
		ST_RESP
	} ufp_state_t;

	ufp_state_t state_q;
	ufp_req_t req_q;
	logic [1:0] lane_q;
	logic req_ready_q;
	logic rsp_valid_q;
	logic [DATA_W-1:0] rdata_q;
	logic [2:0] pops_q;

	logic [NUM_CH-1:0] tx_push;
	logic [NUM_CH-1:0] tx_space;
	logic [NUM_CH-1:0] rx_pop;
	logic [NUM_CH-1:0] rx_head_valid;
	ufp_rx_entry_t [NUM_CH-1:0] rx_head;
	logic [NUM_CH-1:0][RX_W-1:0] rx_head_raw;

	logic cur_ch;
	logic [1:0] cur_win;
	logic take;
	logic moves;
	logic lane_advance;
	logic [7:0] lane_rbyte;
	logic [TX_W-1:0] lane_wbyte;

	// decides whether the current lane of a request moves one FIFO entry
	function automatic logic lane_moves(input ufp_req_t r, input logic [1:0] lane);
		logic [1:0] win;
		logic hit;
		win = r.addr[POS_WIN_HI:POS_WIN_LO];
		hit = r.be[lane];
		case (win)
			WIN_HOLDING: begin
				// only the byte register at word 0, lane 0; other words are not ours
				lane_moves = hit && (lane == LANE_FIRST) && (r.addr[POS_WORD_HI:POS_WORD_LO] == '0);
			end
			WIN_BURST: begin
				lane_moves = hit;
			end
			default: begin
				// status window is read only; the data lane of each pair takes the entry
				lane_moves = hit && !r.write && lane[0];
			end
		endcase
	endfunction

	// true when a request lands in a burst-capable window
	function automatic logic is_window(input ufp_req_t r);
		is_window = (r.addr[POS_WIN_HI:POS_WIN_LO] != WIN_HOLDING);
	endfunction

	assign take = req_valid && req_ready_q;
	assign cur_ch = req_q.addr[POS_CH];
	assign cur_win = req_q.addr[POS_WIN_HI:POS_WIN_LO];
	assign moves = (state_q == ST_LANE) && lane_moves(req_q, lane_q);
	assign lane_wbyte = req_q.wdata[{lane_q, 3'h0} +: 8];
	// reads never stall: an empty receive FIFO yields a zero byte without a pop
	assign lane_advance = (state_q == ST_LANE) && (!moves || !req_q.write || tx_space[cur_ch]);

	always_comb begin
		lane_rbyte = EMPTY_BYTE;
		if (req_q.be[lane_q] && rx_head_valid[cur_ch]) begin
			if (cur_win == WIN_HOLDING) begin
				lane_rbyte = lane_moves(req_q, lane_q) ? rx_head[cur_ch].data : EMPTY_BYTE;
			end else if (cur_win != WIN_BURST && !lane_q[0]) begin
				lane_rbyte = rx_head[cur_ch].line_status_byte;
			end else begin
				lane_rbyte = rx_head[cur_ch].data;
			end
		end
	end

	genvar c;
	generate
		for (c = 0; c < NUM_CH; c++) begin : g_ch
			assign tx_push[c] = moves && req_q.write && (cur_ch == c) && tx_space[c];
			assign rx_pop[c] = moves && !req_q.write && (cur_ch == c) && rx_head_valid[c];
			assign rx_head[c] = ufp_rx_entry_t'(rx_head_raw[c]);

			ufp_fifo #(
				.WIDTH(TX_W),
				.DEPTH(FIFO_DEPTH)
			) u_tx_fifo (
				.ref_clk(ref_clk),
				.rst_n(rst_n),
				.in_valid(tx_push[c]),
				.in_data(lane_wbyte),
				.in_ready(tx_space[c]),
				.out_valid(tx_valid[c]),
				.out_data(tx_data[c]),
				.out_ready(tx_ready[c])
			);

			ufp_fifo #(
				.WIDTH(RX_W),
				.DEPTH(FIFO_DEPTH)
			) u_rx_fifo (
				.ref_clk(ref_clk),
				.rst_n(rst_n),
				.in_valid(rx_valid[c]),
				.in_data(rx_entry[c]),
				.in_ready(rx_ready[c]),
				.out_valid(rx_head_valid[c]),
				.out_data(rx_head_raw[c]),
				.out_ready(rx_pop[c])
			);
		end
	endgenerate

	// request sequencing: one word at a time, its lanes walked lowest first
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			lane_q <= LANE_FIRST;
			req_ready_q <= 1'b1;
			rsp_valid_q <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (take) begin
						state_q <= ST_LANE;
						lane_q <= LANE_FIRST;
						req_ready_q <= 1'b0;
					end
				end
				ST_LANE: begin
					if (lane_advance) begin
						lane_q <= lane_q + 2'h1;
						if (lane_q == LANE_LAST) begin
							state_q <= ST_RESP;
							rsp_valid_q <= 1'b1;
						end
					end
				end
				ST_RESP: begin
					rsp_valid_q <= 1'b0;
					req_ready_q <= 1'b1;
					state_q <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
					req_ready_q <= 1'b1;
					rsp_valid_q <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_q <= '0;
		end else if (take) begin
			req_q <= req;
		end
	end

	// read data collects lane by lane; lane 0 gets the oldest byte
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= RDATA_RESET;
		end else if (take) begin
			rdata_q <= RDATA_RESET;
		end else if (state_q == ST_LANE && !req_q.write) begin
			rdata_q[{lane_q, 3'h0} +: 8] <= lane_rbyte;
		end
	end

	// pops per request, watched by the checks below
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pops_q <= '0;
		end else if (take) begin
			pops_q <= '0;
		end else if (|rx_pop) begin
			pops_q <= pops_q + 3'h1;
		end
	end

	assign req_ready = req_ready_q;
	assign rsp_valid = rsp_valid_q;
	assign rsp_rdata = rdata_q;

	property p_read_latency;
		@(posedge ref_clk) disable iff (!rst_n)
		(take && !req.write) |-> !rsp_valid_q [*5] ##1 rsp_valid_q ##1 !rsp_valid_q;
	endproperty
	a_read_latency: assert property (p_read_latency)
		else $error("read answer not exactly five cycles after take");

	property p_ready_returns;
		@(posedge ref_clk) disable iff (!rst_n)
		rsp_valid_q |=> req_ready_q && (state_q == ST_IDLE);
	endproperty
	a_ready_returns: assert property (p_ready_returns)
		else $error("request port not ready after answer");

	property p_pop_enabled_lane;
		@(posedge ref_clk) disable iff (!rst_n)
		(|rx_pop) |-> req_q.be[lane_q] && !req_q.write && rx_pop[cur_ch];
	endproperty
	a_pop_enabled_lane: assert property (p_pop_enabled_lane)
		else $error("receive pop on a disabled lane or wrong channel");

	property p_push_lane_byte;
		@(posedge ref_clk) disable iff (!rst_n)
		(|tx_push) |-> (req_q.write && req_q.be[lane_q])
			##1 (lane_q != LANE_FIRST || state_q == ST_RESP);
	endproperty
	a_push_lane_byte: assert property (p_push_lane_byte)
		else $error("transmit push without advancing to next lane");

	property p_holding_one_byte;
		@(posedge ref_clk) disable iff (!rst_n)
		(state_q == ST_LANE && cur_win == WIN_HOLDING && lane_q != LANE_FIRST)
			|-> !(|rx_pop) && !(|tx_push);
	endproperty
	a_holding_one_byte: assert property (p_holding_one_byte)
		else $error("holding port moved more than one byte");

	property p_holding_pop;
		@(posedge ref_clk) disable iff (!rst_n)
		(rsp_valid_q && !req_q.write && cur_win == WIN_HOLDING) |-> pops_q <= 3'h1;
	endproperty
	a_holding_pop: assert property (p_holding_pop)
		else $error("holding read popped more than one entry");

	property p_status_pairs;
		@(posedge ref_clk) disable iff (!rst_n)
		(state_q == ST_LANE && cur_win != WIN_HOLDING && cur_win != WIN_BURST && !lane_q[0])
			|-> !(|rx_pop);
	endproperty
	a_status_pairs: assert property (p_status_pairs)
		else $error("status lane popped an entry");

	property p_status_readonly;
		@(posedge ref_clk) disable iff (!rst_n)
		(state_q == ST_LANE && req_q.write && cur_win != WIN_HOLDING && cur_win != WIN_BURST)
			|-> !(|tx_push);
	endproperty
	a_status_readonly: assert property (p_status_readonly)
		else $error("write to status window loaded transmit data");

	property p_burst_pop_count;
		@(posedge ref_clk) disable iff (!rst_n)
		(rsp_valid_q && !req_q.write && cur_win == WIN_BURST)
			|-> pops_q <= 3'($countones(req_q.be));
	endproperty
	a_burst_pop_count: assert property (p_burst_pop_count)
		else $error("burst read popped more entries than enabled lanes");

	property p_window_decode;
		@(posedge ref_clk) disable iff (!rst_n)
		(state_q == ST_LANE && is_window(req_q) && req_q.be[lane_q] && !req_q.write
			&& (cur_win == WIN_BURST || lane_q[0]) && rx_head_valid[cur_ch]) |-> (|rx_pop);
	endproperty
	a_window_decode: assert property (p_window_decode)
		else $error("window read with data waiting did not pop");

	property p_status_byte;
		@(posedge ref_clk) disable iff (!rst_n)
		(state_q == ST_LANE && !req_q.write && cur_win != WIN_HOLDING && cur_win != WIN_BURST
			&& !lane_q[0] && req_q.be[lane_q] && rx_head_valid[cur_ch])
			|=> rdata_q[{$past(lane_q), 3'h0} +: 8] == $past(rx_head[cur_ch].line_status_byte);
	endproperty
	a_status_byte: assert property (p_status_byte)
		else $error("status lane did not carry line status byte");

	property p_write_min_latency;
		@(posedge ref_clk) disable iff (!rst_n)
		(take && req.write) |-> !rsp_valid_q [*5];
	endproperty
	a_write_min_latency: assert property (p_write_min_latency)
		else $error("write answered before all four lanes were walked");

	property p_tx_stall_holds;
		@(posedge ref_clk) disable iff (!rst_n)
		(moves && req_q.write && !tx_space[cur_ch])
			|=> (state_q == ST_LANE) && (lane_q == $past(lane_q));
	endproperty
	a_tx_stall_holds: assert property (p_tx_stall_holds)
		else $error("lane moved on while transmit fifo was full");

	property p_busy_not_ready;
		@(posedge ref_clk) disable iff (!rst_n)
		(state_q != ST_IDLE) |-> !req_ready_q;
	endproperty
	a_busy_not_ready: assert property (p_busy_not_ready)
		else $error("request port ready while a word is in progress");

	property p_empty_read_zero;
		@(posedge ref_clk) disable iff (!rst_n)
		(state_q == ST_LANE && !req_q.write && !rx_head_valid[cur_ch])
			|-> !(|rx_pop) ##1 (rdata_q[{$past(lane_q), 3'h0} +: 8] == EMPTY_BYTE);
	endproperty
	a_empty_read_zero: assert property (p_empty_read_zero)
		else $error("read of empty receive fifo popped or returned nonzero");

	property p_rdata_holds;
		@(posedge ref_clk) disable iff (!rst_n)
		(state_q == ST_IDLE && !take) |=> $stable(rdata_q);
	endproperty
	a_rdata_holds: assert property (p_rdata_holds)
		else $error("read data changed while port idle");

endmodule

// ### tb/ufp_host_model.sv
// ufp_host_model: host requester issuing one aligned memory word per call.
// assumes one rsp_valid pulse answers every taken request.
`timescale 1ns/1ps
module ufp_host_model
	import ufp_pkg::*;
(
	input wire logic ref_clk,
	output logic req_valid,
	output ufp_req_t req,
	input wire logic req_ready,
	input wire logic rsp_valid,
	input wire logic [DATA_W-1:0] rsp_rdata
);
	initial begin
		req_valid = 1'b0;
		req = '0;
	end

	// rd stays unknown when the port never answers, so the caller's compare fails
	task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [LANES-1:0] be, input logic [DATA_W-1:0] wd,
		output logic [DATA_W-1:0] rd);
		int n;
		rd = 'x;
		// status window only in whole status and data pairs
		if (a[POS_WIN_HI] && !(be inside {4'h3, 4'hC, 4'hF}))
			return;
		@(posedge ref_clk);
		#1;
		req_valid = 1'b1;
		req = '{wr, a, be, wd};
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (req_ready !== 1'b1 && n < 100);
		#1;
		req_valid = 1'b0;
		// a released bus shows the inverse, never a stale copy
		req = ~req;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (rsp_valid !== 1'b1 && n < 3000);
		if (rsp_valid === 1'b1)
			rd = rsp_rdata;
	endtask
endmodule

// ### tb/tb_uart_fifo_host_data_port.sv
// tb_uart_fifo_host_data_port: self-checking bench for the two-channel data port.
// assumes the host model drives requests; the bench plays the serial side.
`timescale 1ns/1ps
module tb_uart_fifo_host_data_port
	import ufp_pkg::*;
;
	logic ref_clk, rst_n, req_valid, req_ready, rsp_valid;
	ufp_req_t req;
	logic [DATA_W-1:0] rsp_rdata, rd;
	logic [NUM_CH-1:0] tx_valid, tx_ready, rx_valid, rx_ready;
	logic [NUM_CH-1:0][TX_W-1:0] tx_data;
	ufp_rx_entry_t [NUM_CH-1:0] rx_entry;
	logic [7:0] txq0[$], txq1[$], expq[$];
	int num_errors, comparisons;

	ufp_data_port dut (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
		.rx_entry(rx_entry), .rx_ready(rx_ready));
	ufp_host_model host (.ref_clk(ref_clk), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		if (tx_valid[0] === 1'b1 && tx_ready[0] === 1'b1)
			txq0.push_back(tx_data[0]);
		if (tx_valid[1] === 1'b1 && tx_ready[1] === 1'b1)
			txq1.push_back(tx_data[1]);
	end

	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic rx_push(int ch, logic [7:0] s, logic [7:0] d);
		int n;
		@(posedge ref_clk);
		#1;
		rx_valid[ch] = 1'b1;
		rx_entry[ch] = {s, d};
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (rx_ready[ch] !== 1'b1 && n < 100);
		#1;
		rx_valid[ch] = 1'b0;
		rx_entry[ch] = ~rx_entry[ch];
	endtask

	// entry i carries status A0+i and data b+i
	task automatic fill(int ch, int cnt, logic [7:0] b);
		for (int i = 0; i < cnt; i++)
			rx_push(ch, 8'hA0 + 8'(i), b + 8'(i));
		repeat (3) @(posedge ref_clk);
	endtask

	task automatic rd_chk(logic [10:0] a, logic [3:0] be, logic [31:0] exp);
		host.xfer(1'b0, a, be, 32'h0, rd);
		chk("rdata", rd, exp);
	endtask

	task automatic t_rx_burst(int ch);
		logic [10:0] a;
		logic [7:0] b;
		a = ch[0] ? OFS_CH1_BURST : OFS_CH0_BURST;
		b = 8'h10 + 8'(ch * 8'h40);
		fill(ch, 8, b);
		rd_chk(a, 4'hF, {b + 8'h3, b + 8'h2, b + 8'h1, b});
		rd_chk(a | 11'h0FC, 4'hF, {b + 8'h7, b + 8'h6, b + 8'h5, b + 8'h4});
		rd_chk(a, 4'hF, 32'h0);
	endtask

	task automatic t_rx_status(int ch);
		logic [10:0] a;
		logic [7:0] b;
		a = ch[0] ? OFS_CH1_RX_STATUS : OFS_CH0_RX_STATUS;
		b = 8'h20 + 8'(ch * 8'h40);
		fill(ch, 4, b);
		rd_chk(a, 4'hF, {b + 8'h1, 8'hA1, b, 8'hA0});
		rd_chk(a | 11'h1FC, 4'h3, {16'h0, b + 8'h2, 8'hA2});
		rd_chk(a, 4'hC, {b + 8'h3, 8'hA3, 16'h0});
	endtask

	// a full 256-byte burst is held back, then partial words follow
	task automatic t_tx(int ch);
		logic [10:0] a;
		logic [31:0] w;
		logic [3:0] bes[4] = '{4'h1, 4'h3, 4'h7, 4'h6};
		a = ch[0] ? OFS_CH1_BURST : OFS_CH0_BURST;
		txq0.delete();
		txq1.delete();
		expq.delete();
		#1;
		tx_ready[ch] = 1'b0;
		for (int i = 0; i < 64; i++) begin
			w = {8'(4 * i + 3), 8'(4 * i + 2), 8'(4 * i + 1), 8'(4 * i)};
			host.xfer(1'b1, a + 11'(4 * i), 4'hF, w, rd);
			for (int k = 0; k < 4; k++)
				expq.push_back(w[8 * k +: 8]);
		end
		// one more word overfills the held FIFO; the stalled lanes must survive the drain
		fork
			host.xfer(1'b1, a, 4'hF, 32'hE3E2E1E0, rd);
			begin
				repeat (40) @(posedge ref_clk);
				#1;
				tx_ready[ch] = 1'b1;
			end
		join
		chk("stalled write answer", rd, 32'h0);
		for (int k = 0; k < 4; k++)
			expq.push_back(8'hE0 + 8'(k));
		for (int j = 0; j < 4; j++) begin
			host.xfer(1'b1, a, bes[j], 32'hF4F3F2F1, rd);
			for (int k = 0; k < 4; k++)
				if (bes[j][k])
					expq.push_back(8'hF1 + 8'(k));
		end
		repeat (300) @(posedge ref_clk);
		chk("tx count", ch[0] ? 32'(txq1.size()) : 32'(txq0.size()), 32'd268);
		for (int i = 0; i < 268 && i < expq.size(); i++)
			chk("tx byte", ch[0] ? txq1[i] : txq0[i], expq[i]);
	endtask

	task automatic t_hold;
		txq0.delete();
		txq1.delete();
		host.xfer(1'b1, OFS_CH0_HOLDING, 4'hF, 32'h44332211, rd);
		host.xfer(1'b1, OFS_CH1_RX_STATUS, 4'hF, 32'h55667788, rd);
		fill(1, 2, 8'h70);
		rd_chk(OFS_CH1_HOLDING, 4'hF, 32'h70);
		rd_chk(OFS_CH1_BURST, 4'h1, 32'h71);
		repeat (20) @(posedge ref_clk);
		chk("hold tx count", 32'(txq0.size()), 32'd1);
		chk("hold tx byte", txq0.size() > 0 ? txq0[0] : 8'hXX, 8'h11);
		chk("status window write", 32'(txq1.size()), 32'd0);
	endtask

	initial begin
		#3000000;
		num_errors++;
		conclude();
	end

	initial begin
		rst_n = 1'b0;
		tx_ready = '1;
		rx_valid = '0;
		rx_entry = '0;
		repeat (20) @(posedge ref_clk);
		#1;
		chk("reset ready", {req_ready, rsp_valid, tx_valid, rx_ready}, 32'h23);
		chk("reset rdata", rsp_rdata, 32'h0);
		rst_n = 1'b1;
		for (int ch = 0; ch < NUM_CH; ch++) begin
			t_rx_burst(ch);
			t_rx_status(ch);
			t_tx(ch);
		end
		t_hold();
		conclude();
	end
endmodule
